// File: sim/pms_board_model.sv
// Board reset, strap, PLL lock and debug controller model at the block's pins
`timescale 1ns/1ps
`default_nettype none
module pms_board_model (
  // Clock and PLL setting from the block
  input wire logic clock,
  input wire logic pll_bypass,
  input wire logic [3:0] pll_factor,
  // Commands from the bench
  input wire logic sys_cmd,
  input wire logic trst_cmd,
  input wire logic drive_cmd,
  input wire logic [1:0] mult_cmd,
  input wire logic [1:0] dbg_cmd,
  input wire logic [15:0] lock_delay,
  // Pins
  output logic sys_reset_n,
  output logic test_reset_n,
  output logic test_reset_driven,
  output logic [1:0] mult_strap,
  output logic [1:0] dbg_strap,
  output logic pll_lock
);
  logic [15:0] lock_cnt_q;
  logic [3:0] fact_q;
  // Reset pins; bench holds both low from power-up
  assign sys_reset_n = sys_cmd;
  // Floating test reset line falls to the pulldown level
  assign test_reset_n = drive_cmd ? trst_cmd : 1'b0;
  assign test_reset_driven = drive_cmd;
  // Strap resistors
  assign mult_strap = mult_cmd;
  assign dbg_strap = dbg_cmd;
  // PLL relocks a set number of cycles after bypass drops or the factor moves
  always_ff @(posedge clock) begin
    fact_q <= pll_factor;
    if (pll_bypass || pll_factor != fact_q) begin
      lock_cnt_q <= 16'h0;
    end else if (lock_cnt_q != lock_delay) begin
      lock_cnt_q <= lock_cnt_q + 16'h1;
    end
  end
  assign pll_lock = !pll_bypass && (pll_factor == fact_q) && (lock_cnt_q == lock_delay);
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the PLL mode select and test reset block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pms_pkg::*;
  localparam int LOCK_WAIT = 40;
  localparam int TIME_LIMIT = 5000;
  typedef struct packed {
    logic [1:0] mult;
    logic byp;
    logic [3:0] fact;
    logic [1:0] st;
  } pms_row_t;
  pms_row_t rows[4] = '{'{2'h0, 1'b1, 4'h1, 2'h3}, '{2'h1, 1'b0, 4'h6, 2'h3},
                        '{2'h2, 1'b0, 4'hc, 2'h3}, '{2'h3, 1'b1, 4'h1, 2'h2}};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sys_cmd = 1'b0;
  logic trst_cmd = 1'b0;
  logic drive_cmd = 1'b0;
  logic [1:0] mult_cmd = 2'h0;
  logic [1:0] dbg_cmd = 2'h0;
  logic [15:0] lock_delay = 16'd20;
  logic hreadyout, hresp, sys_n, trst_n, trst_drv, lock, byp, stable, core_rst, dbg_rst;
  logic valid, div4, div6;
  logic [31:0] hrdata, rd;
  logic [1:0] mult_s, dbg_s, dmode;
  logic [3:0] fact;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int r4, h4, r6, h6;
  logic p4, p6;

  // Clock
  always #2 clock = ~clock;

  pms_board_model board_u (.clock(clock), .pll_bypass(byp), .pll_factor(fact), .sys_cmd(sys_cmd),
    .trst_cmd(trst_cmd), .drive_cmd(drive_cmd), .mult_cmd(mult_cmd), .dbg_cmd(dbg_cmd),
    .lock_delay(lock_delay), .sys_reset_n(sys_n), .test_reset_n(trst_n),
    .test_reset_driven(trst_drv), .mult_strap(mult_s), .dbg_strap(dbg_s), .pll_lock(lock));

  pms_top #(.LOCK_WAIT_CYCLES(LOCK_WAIT)) dut_u (.clock(clock), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sys_reset_n(sys_n), .test_reset_n(trst_n), .test_reset_driven(trst_drv),
    .pll_mult_select_hi(mult_s[1]), .pll_mult_select_lo(mult_s[0]),
    .debug_mode_strap_hi(dbg_s[1]), .debug_mode_strap_lo(dbg_s[0]), .pll_lock(lock),
    .pll_bypass(byp), .pll_factor(fact), .core_clock_stable(stable), .core_reset(core_rst),
    .debug_reset(dbg_rst), .debug_mode(dmode), .debug_mode_valid(valid),
    .core_div4_clock_out(div4), .core_div6_clock_out(div6));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: %0d checks, %0d errors", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Single AHB-Lite word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  // Hold system reset with new straps, then release it
  task automatic boot(input logic [1:0] m);
    @(posedge clock);
    sys_cmd <= 1'b0;
    mult_cmd <= m;
    repeat (4) @(posedge clock);
    sys_cmd <= 1'b1;
  endtask

  // Count rises and high cycles of both divided clocks over 24 cycles
  task automatic sample_div();
    r4 = 0; h4 = 0; r6 = 0; h6 = 0;
    @(negedge clock);
    p4 = div4;
    p6 = div6;
    repeat (24) begin
      @(negedge clock);
      r4 += int'(div4 === 1'b1 && p4 === 1'b0);
      h4 += int'(div4 === 1'b1);
      r6 += int'(div6 === 1'b1 && p6 === 1'b0);
      h6 += int'(div6 === 1'b1);
      p4 = div4;
      p6 = div6;
    end
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == TIME_LIMIT) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk(hreadyout, 1, "hreadyout");
    chk(hresp, HRESP_OKAY, "hresp");
    chk({byp, fact}, {1'b1, FACT_X1}, "reset config");
    chk({core_rst, dbg_rst, valid}, 3'b110, "reset outputs");
    bus(1'b0, REG_CTRL, 0);
    chk(rd, 32'h1, "ctrl reset");
    bus(1'b1, 8'h40, 32'hffffffff);
    bus(1'b0, 8'h40, 0);
    chk(rd, 0, "unmapped read");
    // Every strap code, bypass and multiply modes and the reserved one
    foreach (rows[i]) begin
      boot(rows[i].mult);
      repeat (8) @(posedge clock);
      @(negedge clock);
      chk(stable, rows[i].mult == MSEL_BYPASS, "stable before lock");
      repeat (40) @(posedge clock);
      @(negedge clock);
      chk({byp, fact}, {rows[i].byp, rows[i].fact}, "pll config");
      chk({stable, core_rst}, {rows[i].st == 2'h3, rows[i].st != 2'h3}, "core state");
      bus(1'b0, REG_STATUS, 0);
      chk({rd[17:16], rd[3]}, {rows[i].st, rows[i].mult == MSEL_RSVD}, "status");
    end
    // Slow lock: timeout flag, still not stable, then lock and clear
    lock_delay <= 16'd80;
    boot(MSEL_X6);
    repeat (52) @(posedge clock);
    bus(1'b0, REG_STATUS, 0);
    chk({rd[2], rd[0]}, 2'b10, "timeout no stable");
    repeat (60) @(posedge clock);
    @(negedge clock);
    chk({stable, core_rst}, 2'b10, "stable after lock");
    bus(1'b1, REG_STATUS, 32'h4);
    bus(1'b0, REG_STATUS, 0);
    chk(rd[2], 0, "timeout cleared");
    // Divided clocks in multiply mode, then gated off
    sample_div();
    chk(r4, 32'd6, "div4 rises");
    chk(h4, 32'd12, "div4 high");
    chk(r6, 32'd4, "div6 rises");
    chk(h6, 32'd12, "div6 high");
    bus(1'b1, REG_CTRL, 0);
    sample_div();
    chk(r4 + h4 + r6 + h6, 0, "div gated");
    // Relock pulse: core back in reset until lock, pulse bit reads zero
    bus(1'b1, REG_CTRL, 32'h3);
    @(negedge clock);
    chk({stable, core_rst}, 2'b01, "relock restarts wait");
    bus(1'b0, REG_LOCKCNT, 0);
    chk(rd, 0, "lock count after relock");
    bus(1'b0, REG_CTRL, 0);
    chk(rd, 32'h1, "relock reads zero");
    // Test reset held low: debug held, core keeps running
    @(posedge clock);
    dbg_cmd <= 2'h2;
    drive_cmd <= 1'b1;
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk({dbg_rst, valid, stable}, 3'b101, "debug held");
    @(posedge clock);
    trst_cmd <= 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk({dbg_rst, valid, dmode}, {2'b01, 2'h2}, "capture straps");
    bus(1'b0, REG_STATUS, 0);
    chk({rd[14:12], rd[5]}, 4'b1100, "status debug");
    // Floating pin reads as asserted
    @(posedge clock);
    drive_cmd <= 1'b0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk(dbg_rst, 1, "float asserts");
    // Rising edge while system reset held is ignored
    @(posedge clock);
    sys_cmd <= 1'b0;
    dbg_cmd <= 2'h1;
    drive_cmd <= 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk({valid, core_rst}, 2'b01, "no capture in reset");
    @(posedge clock);
    sys_cmd <= 1'b1;
    trst_cmd <= 1'b0;
    repeat (6) @(posedge clock);
    trst_cmd <= 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk({valid, dmode}, {1'b1, 2'h1}, "capture after release");
    end_sim();
  end
endmodule
`default_nettype wire

// File: src/pms_divider.sv
// Even ratio clock divider with a synchronous enable
`timescale 1ns/1ps
`default_nettype none
module pms_divider #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic enable,
  // Divided clock
  output logic clk_out_q
);

  localparam int HALF = DIV / 2;
  localparam logic [3:0] HALF_LAST = 4'(HALF - 1);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic clk_out_d;

  // Toggle every half period, parked low when disabled
  always_comb begin
    cnt_d = cnt_q + 4'h1;
    clk_out_d = clk_out_q;
    if (!enable) begin
      cnt_d = 4'h0;
      clk_out_d = 1'b0;
    end else if (cnt_q == HALF_LAST) begin
      cnt_d = 4'h0;
      clk_out_d = ~clk_out_q;
    end
  end

  // Register the divider state
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q <= 4'h0;
      clk_out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_out_q <= clk_out_d;
    end
  end

endmodule
`default_nettype wire

// File: src/pms_pkg.sv
// Constants, codes and carriers for the PLL mode select and test reset block
package pms_pkg;

  // Timing: core clock period and PLL lock wait
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int LOCK_TYP_US = 75;
  localparam int LOCK_MARGIN_PCT = 150;
  localparam int LOCK_MAX_PS = LOCK_TYP_US * 1000000 / 100 * (100 + LOCK_MARGIN_PCT);
  localparam int LOCK_MAX_CYCLES = LOCK_MAX_PS / CLOCK_PERIOD_PS;
  localparam int LOCK_CNT_W = 16;

  // Auxiliary clock divide ratios
  localparam int DIV_A = 4;
  localparam int DIV_B = 6;

  // Multiply select strap codes
  localparam logic [1:0] MSEL_BYPASS = 2'h0;
  localparam logic [1:0] MSEL_X6 = 2'h1;
  localparam logic [1:0] MSEL_X12 = 2'h2;
  localparam logic [1:0] MSEL_RSVD = 2'h3;

  // Multiply factors driven to the PLL
  localparam logic [3:0] FACT_X1 = 4'h1;
  localparam logic [3:0] FACT_X6 = 4'h6;
  localparam logic [3:0] FACT_X12 = 4'hc;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LOCKCNT = 8'h08;

  // Control register fields
  localparam int CTRL_DIV_EN_BIT = 0;
  localparam int CTRL_RELOCK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Status register fields
  localparam int ST_STABLE_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_TIMEOUT_BIT = 2;
  localparam int ST_RSVD_BIT = 3;
  localparam int ST_CORE_RST_BIT = 4;
  localparam int ST_DBG_RST_BIT = 5;
  localparam int ST_MSEL_LSB = 8;
  localparam int ST_DBG_MODE_LSB = 12;
  localparam int ST_DBG_VALID_BIT = 14;
  localparam int ST_STATE_LSB = 16;

  // AHB transfer types and responses
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Clock sequencing states, Gray along reset, wait, run
  typedef enum logic [1:0] {
    PMS_IN_RESET = 2'h0,
    PMS_LOCK_WAIT = 2'h1,
    PMS_RUNNING = 2'h3,
    PMS_FAULT = 2'h2
  } pms_state_t;

  // Clock configuration sent to the PLL
  typedef struct packed {
    logic bypass;
    logic [3:0] factor;
  } pms_clk_cfg_t;

  // Pin levels after synchronisation
  typedef struct packed {
    logic sys_reset_n;
    logic test_reset_n;
    logic pll_lock;
    logic [1:0] mult;
    logic [1:0] dbg;
  } pms_pins_t;

  localparam pms_clk_cfg_t CFG_RESET = '{bypass: 1'b1, factor: 4'h1};
  localparam pms_pins_t PINS_RESET = '{sys_reset_n: 1'b0, test_reset_n: 1'b0,
                                       pll_lock: 1'b0, mult: 2'h0, dbg: 2'h0};

endpackage

// File: src/pms_top.sv
// PLL mode select, lock sequencing, test reset handling and AHB-Lite registers
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Core clock comes from the reference, through the PLL or bypassing it.
// - Straps 00 bypass x1, 01 x6, 10 x12, 11 reserved.
// - In multiply modes the clock is stable only after lock; wait allows 150% margin.
// - System reset holds the core; test reset holds the debug logic.
// - Held test reset keeps debug in reset without disturbing normal operation.
// - Undriven test reset input reads as asserted through an internal pulldown.
// - After system reset release, test reset rising edge captures the debug straps.
module pms_top
  import pms_pkg::*;
#(
  parameter int LOCK_WAIT_CYCLES = LOCK_MAX_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Board pins
  input wire logic sys_reset_n,
  input wire logic test_reset_n,
  input wire logic test_reset_driven,
  input wire logic pll_mult_select_hi,
  input wire logic pll_mult_select_lo,
  input wire logic debug_mode_strap_hi,
  input wire logic debug_mode_strap_lo,
  input wire logic pll_lock,
  // PLL control and status
  output logic pll_bypass,
  output logic [3:0] pll_factor,
  output logic core_clock_stable,
  // Resets and debug mode
  output logic core_reset,
  output logic debug_reset,
  output logic [1:0] debug_mode,
  output logic debug_mode_valid,
  // Auxiliary clocks
  output logic core_div4_clock_out,
  output logic core_div6_clock_out
);

  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_WAIT_CYCLES - 1);

  pms_pins_t pins_raw;
  pms_pins_t sync1_q;
  pms_pins_t sync2_q;
  logic test_prev_q;
  pms_state_t state_q, state_d;
  pms_clk_cfg_t cfg_q, cfg_d;
  logic [1:0] msel_q, msel_d;
  logic [LOCK_CNT_W-1:0] cnt_q, cnt_d;
  logic [LOCK_CNT_W-1:0] lockcnt_q, lockcnt_d;
  logic stable_q, stable_d;
  logic core_rst_q, core_rst_d;
  logic timeout_q, timeout_d;
  logic rsvd_q, rsvd_d;
  logic dbg_rst_q, dbg_rst_d;
  logic [1:0] dbg_mode_q, dbg_mode_d;
  logic dbg_valid_q, dbg_valid_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic relock;
  logic div_run;
  logic accept;
  logic wr_pend_q, wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic hready_q;

  // Pulldown on test reset: undriven reads as asserted
  always_comb begin
    pins_raw.sys_reset_n = sys_reset_n;
    pins_raw.test_reset_n = test_reset_driven & test_reset_n;
    pins_raw.pll_lock = pll_lock;
    pins_raw.mult = {pll_mult_select_hi, pll_mult_select_lo};
    pins_raw.dbg = {debug_mode_strap_hi, debug_mode_strap_lo};
  end

  // Two-stage pin synchroniser plus test reset history
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_q <= PINS_RESET;
      sync2_q <= PINS_RESET;
      test_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      test_prev_q <= sync2_q.test_reset_n;
    end
  end

  // Bus accepts and register decode
  assign accept = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == 2'h3);
  assign relock = wr_pend_q & (wr_addr_q == REG_CTRL) & hwdata[CTRL_RELOCK_BIT];
  assign div_run = ctrl_q[CTRL_DIV_EN_BIT] & stable_q;

  // Clock sequencing: strap decode, lock wait, core reset release
  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    msel_d = msel_q;
    cnt_d = cnt_q;
    lockcnt_d = lockcnt_q;
    stable_d = 1'b0;
    core_rst_d = 1'b1;
    timeout_d = timeout_q;
    rsvd_d = rsvd_q;
    if (wr_pend_q && wr_addr_q == REG_STATUS && hwdata[ST_TIMEOUT_BIT]) begin
      timeout_d = 1'b0;
    end
    case (state_q)
      PMS_IN_RESET: begin
        msel_d = sync2_q.mult;
        rsvd_d = (sync2_q.mult == MSEL_RSVD);
        case (sync2_q.mult)
          MSEL_X6: cfg_d = '{bypass: 1'b0, factor: FACT_X6};
          MSEL_X12: cfg_d = '{bypass: 1'b0, factor: FACT_X12};
          default: cfg_d = CFG_RESET;
        endcase
        cnt_d = '0;
        if (sync2_q.sys_reset_n) begin
          if (sync2_q.mult == MSEL_RSVD) begin
            state_d = PMS_FAULT;
          end else if (sync2_q.mult == MSEL_BYPASS) begin
            state_d = PMS_RUNNING;
          end else begin
            state_d = PMS_LOCK_WAIT;
          end
        end
      end
      PMS_LOCK_WAIT: begin
        if (cnt_q != LOCK_LAST) begin
          cnt_d = cnt_q + 1'b1;
        end else begin
          timeout_d = 1'b1;
        end
        if (sync2_q.pll_lock) begin
          state_d = PMS_RUNNING;
          lockcnt_d = cnt_q;
        end
      end
      PMS_RUNNING: begin
        stable_d = 1'b1;
        core_rst_d = 1'b0;
        if (!cfg_q.bypass && (!sync2_q.pll_lock || relock)) begin
          state_d = PMS_LOCK_WAIT;
          cnt_d = '0;
          stable_d = 1'b0;
          core_rst_d = 1'b1;
        end
      end
      PMS_FAULT: begin
        state_d = PMS_FAULT;
      end
      default: begin
        state_d = PMS_IN_RESET;
      end
    endcase
    if (!sync2_q.sys_reset_n) begin
      state_d = PMS_IN_RESET;
      stable_d = 1'b0;
      core_rst_d = 1'b1;
    end
  end

  // Register the clock sequencing state
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= PMS_IN_RESET;
      cfg_q <= CFG_RESET;
      msel_q <= MSEL_BYPASS;
      cnt_q <= '0;
      lockcnt_q <= '0;
      stable_q <= 1'b0;
      core_rst_q <= 1'b1;
      timeout_q <= 1'b0;
      rsvd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      msel_q <= msel_d;
      cnt_q <= cnt_d;
      lockcnt_q <= lockcnt_d;
      stable_q <= stable_d;
      core_rst_q <= core_rst_d;
      timeout_q <= timeout_d;
      rsvd_q <= rsvd_d;
    end
  end

  // Debug reset and strap capture, independent of the core path
  always_comb begin
    dbg_rst_d = ~sync2_q.test_reset_n;
    dbg_mode_d = dbg_mode_q;
    dbg_valid_d = dbg_valid_q;
    if (!sync2_q.sys_reset_n) begin
      dbg_valid_d = 1'b0;
    end else if (sync2_q.test_reset_n && !test_prev_q) begin
      dbg_mode_d = sync2_q.dbg;
      dbg_valid_d = 1'b1;
    end
  end

  // Register the debug state
  always_ff @(posedge clock) begin
    if (reset) begin
      dbg_rst_q <= 1'b1;
      dbg_mode_q <= 2'h0;
      dbg_valid_q <= 1'b0;
    end else begin
      dbg_rst_q <= dbg_rst_d;
      dbg_mode_q <= dbg_mode_d;
      dbg_valid_q <= dbg_valid_d;
    end
  end

  // Status word and read mux
  always_comb begin
    status_word = 32'h0;
    status_word[ST_STABLE_BIT] = stable_q;
    status_word[ST_LOCK_BIT] = sync2_q.pll_lock;
    status_word[ST_TIMEOUT_BIT] = timeout_q;
    status_word[ST_RSVD_BIT] = rsvd_q;
    status_word[ST_CORE_RST_BIT] = core_rst_q;
    status_word[ST_DBG_RST_BIT] = dbg_rst_q;
    status_word[ST_MSEL_LSB +: 2] = msel_q;
    status_word[ST_DBG_MODE_LSB +: 2] = dbg_mode_q;
    status_word[ST_DBG_VALID_BIT] = dbg_valid_q;
    status_word[ST_STATE_LSB +: 2] = state_q;
    case (haddr[ADDR_W-1:0])
      REG_CTRL: rd_word = {30'h0, ctrl_q};
      REG_STATUS: rd_word = status_word;
      REG_LOCKCNT: rd_word = {16'h0, lockcnt_q};
      default: rd_word = 32'h0;
    endcase
  end

  // Bus address and data phases, zero wait states
  always_comb begin
    wr_pend_d = accept & hwrite;
    wr_addr_d = accept ? haddr[ADDR_W-1:0] : wr_addr_q;
    hrdata_d = (accept && !hwrite) ? rd_word : 32'h0;
    ctrl_d = ctrl_q;
    if (wr_pend_q && wr_addr_q == REG_CTRL) begin
      ctrl_d[CTRL_DIV_EN_BIT] = hwdata[CTRL_DIV_EN_BIT];
    end
  end

  // Register the bus state
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= 32'h0;
      ctrl_q <= CTRL_RESET;
      hready_q <= 1'b1;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      ctrl_q <= ctrl_d;
      hready_q <= 1'b1;
    end
  end

  // Auxiliary clock dividers
  pms_divider #(.DIV(DIV_A)) u_div4 (
    .clock(clock),
    .reset(reset),
    .enable(div_run),
    .clk_out_q(core_div4_clock_out)
  );

  pms_divider #(.DIV(DIV_B)) u_div6 (
    .clock(clock),
    .reset(reset),
    .enable(div_run),
    .clk_out_q(core_div6_clock_out)
  );

  // Output drive from flops, with hresp tied to OKAY
  assign hreadyout = hready_q;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;
  assign pll_bypass = cfg_q.bypass;
  assign pll_factor = cfg_q.factor;
  assign core_clock_stable = stable_q;
  assign core_reset = core_rst_q;
  assign debug_reset = dbg_rst_q;
  assign debug_mode = dbg_mode_q;
  assign debug_mode_valid = dbg_valid_q;

  // Checks on the clock, reset and debug behaviour
  property p_bypass_cfg;
    @(posedge clock) disable iff (reset)
      (state_q == PMS_RUNNING) |-> (cfg_q.bypass == (cfg_q.factor == FACT_X1));
  endproperty
  a_bypass_cfg: assert property (p_bypass_cfg) else $error("bypass and factor disagree");

  property p_x12_decode;
    @(posedge clock) disable iff (reset)
      (state_q == PMS_IN_RESET && sync2_q.mult == MSEL_X12) |=>
        (cfg_q.factor == FACT_X12 && !cfg_q.bypass);
  endproperty
  a_x12_decode: assert property (p_x12_decode) else $error("x12 strap not decoded");

  property p_stable_after_lock;
    @(posedge clock) disable iff (reset)
      ($rose(stable_q) && !cfg_q.bypass) |-> $past(sync2_q.pll_lock, 2);
  endproperty
  a_stable_after_lock: assert property (p_stable_after_lock) else $error("stable without lock");

  property p_core_held;
    @(posedge clock) disable iff (reset)
      !sync2_q.sys_reset_n |=> (core_rst_q && !stable_q);
  endproperty
  a_core_held: assert property (p_core_held) else $error("core left reset early");

  property p_debug_held;
    @(posedge clock) disable iff (reset)
      (!sync2_q.test_reset_n && state_q == PMS_RUNNING && sync2_q.sys_reset_n &&
       (cfg_q.bypass || sync2_q.pll_lock) && !relock) |=> (dbg_rst_q && !core_rst_q);
  endproperty
  a_debug_held: assert property (p_debug_held) else $error("test reset disturbed core");

  property p_pulldown;
    @(posedge clock) disable iff (reset)
      (!test_reset_driven)[*3] |=> dbg_rst_q;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("undriven test reset not asserted");

  property p_strap_capture;
    @(posedge clock) disable iff (reset)
      (sync2_q.sys_reset_n && $rose(sync2_q.test_reset_n) && !test_prev_q) |=>
        (dbg_valid_q && dbg_mode_q == $past(sync2_q.dbg));
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("debug strap not latched");

  property p_div4_half;
    @(posedge clock) disable iff (reset)
      ($rose(core_div4_clock_out) ##1 div_run[*2]) |-> !core_div4_clock_out;
  endproperty
  a_div4_half: assert property (p_div4_half) else $error("divide by four period wrong");

  property p_div6_half;
    @(posedge clock) disable iff (reset)
      ($rose(core_div6_clock_out) ##1 div_run[*3]) |-> !core_div6_clock_out;
  endproperty
  a_div6_half: assert property (p_div6_half) else $error("divide by six period wrong");

endmodule
`default_nettype wire
